// >>> rtl/slc_pkg.sv
// Types shared by the link switch decoder.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package slc_pkg;

    // Self-test motion sequence, Gray coded from SLC_ST_IDLE through SLC_ST_CENTER; the return to SLC_ST_IDLE flips all three bits
    typedef enum logic [2:0] {
        SLC_ST_IDLE     = 3'h0,
        SLC_ST_PAN_POS  = 3'h1,
        SLC_ST_PAN_NEG  = 3'h3,
        SLC_ST_TILT_POS = 3'h2,
        SLC_ST_TILT_NEG = 3'h6,
        SLC_ST_CENTER   = 3'h7
    } slc_state_e;

    typedef logic [7:0] slc_deg_t;

endpackage : slc_pkg

`default_nettype wire

// >>> rtl/slc_regs.svh
// Register offsets, field positions, reset values and timing for the link switch decoder.
// Assumes byte addressing on APB with 32-bit aligned words.
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

// Register byte offsets
`define SLC_ADDR_FMT        8'h00
`define SLC_ADDR_NODE       8'h04
`define SLC_ADDR_LENS       8'h08
`define SLC_ADDR_CTRL       8'h0c
`define SLC_ADDR_TEST       8'h10

// Format switch bank positions (position n sits at bit n-1)
`define SLC_FMT_STOP_BIT    0
`define SLC_FMT_DATA_BIT    1
`define SLC_FMT_PAR_LSB     2
`define SLC_FMT_PAR_MSB     4
`define SLC_FMT_BAUD_LSB    5
`define SLC_FMT_BAUD_MSB    7

// Parity codes
`define SLC_PAR_EVEN        3'h5
`define SLC_PAR_ODD         3'h6
`define SLC_PAR_NONE        3'h7

// Baud code of the fixed default format, and all-on format reset value
`define SLC_BAUD_9600       3'h5
`define SLC_FMT_RESET       8'hff

// Node number as delivered, and the lowest valid one
`define SLC_NODE_RESET      8'h5a
`define SLC_NODE_MIN        8'h01

// CTRL fields
`define SLC_CTRL_START_BIT  0
`define SLC_CTRL_FORCE_BIT  1

// Self-test motion size in degrees, two's complement
`define SLC_TEST_DEG_POS    8'h0a
`define SLC_TEST_DEG_NEG    8'hf6
`define SLC_TEST_DEG_ZERO   8'h00

// Timing
`define SLC_CLK_PERIOD_NS   100
`define SLC_STEP_TIME_US    100000
`define SLC_STEP_CYCLES     ((`SLC_STEP_TIME_US * 1000) / `SLC_CLK_PERIOD_NS)

`endif

// >>> rtl/slc_switch_config.sv
// Switch and jumper decoder for the serial and network control links, with APB status.
// Assumes all switch pins are asynchronous levels, on = 1, and a zero-wait APB master.
// Notes on behaviour
// [R1] Format position 1 picks stop bits, position 2 picks 7 or 8 data bits.
// [R2] Positions 3..5 code parity: 101 even, 110 odd, 111 none, others unused.
// [R3] Positions 6..8 code baud, 000 is 300 up to 111 for 38400.
// [R4] A fixed default format exists: 9600 baud, no parity, 8 data, 1 stop.
// [R5] Node number is the binary weighted sum of the eight station positions.
// [R6] Only node numbers 1 to 255 are accepted.
// [R7] Station bank ships set to node 90.
// [R8] A new node number is captured only on network reconnection; the code also captures it once after reset release.
// [R9] Controller software must use the same node number as the station bank.
// [R10] Setup button runs a preset series of 10 degree pan and tilt motions.
// [R11] Self-test moves each axis both ways, then centres both axes.
// [R12] Three jumpers select network or serial link; network is the default.
// [R13] Zoom, focus, iris each pick servo or motor; one switch picks 6 or 12 V.
// [R14] Pins pass two flops; format is latched once after reset release.
// [R15] Unused parity code forces default format; node zero means no network presence.
`default_nettype none
`include "slc_regs.svh"

module slc_switch_config #(
    parameter int unsigned STEP_CYCLES = `SLC_STEP_CYCLES
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Pins
    input  wire logic [7:0]  serial_format_switch_i,
    input  wire logic [7:0]  station_number_switch_i,
    input  wire logic        link_select_jumper_a_i,
    input  wire logic        link_select_jumper_b_i,
    input  wire logic        link_select_jumper_c_i,
    input  wire logic        zoom_motor_sw_i,
    input  wire logic        focus_motor_sw_i,
    input  wire logic        iris_motor_sw_i,
    input  wire logic        volt_12_sw_i,
    input  wire logic        setup_button_i,
    input  wire logic        net_connected_i,
    // Serial port settings
    output logic             stop_two_o,
    output logic             data_eight_o,
    output logic             parity_en_o,
    output logic             parity_odd_o,
    output logic      [2:0]  baud_code_o,
    output logic             fmt_default_o,
    // Network and link
    output logic      [7:0]  node_number_o,
    output logic             node_valid_o,
    output logic             link_serial_o,
    // Lens drive
    output logic             zoom_motor_o,
    output logic             focus_motor_o,
    output logic             iris_motor_o,
    output logic             volt_12_o,
    // Self-test motion targets
    output logic             test_busy_o,
    output logic      [7:0]  test_pan_deg_o,
    output logic      [7:0]  test_tilt_deg_o
);

    logic [7:0] fmt_sync;
    logic [7:0] stn_sync;
    logic [2:0] jmp_sync;
    logic [3:0] lens_sync;
    logic       btn_sync;
    logic       conn_sync;

    slc_sync #(.W(8)) u_sync_fmt (  // see [R14]
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   (serial_format_switch_i),
        .sync_o    (fmt_sync)
    );

    slc_sync #(.W(8)) u_sync_stn (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   (station_number_switch_i),
        .sync_o    (stn_sync)
    );

    slc_sync #(.W(9)) u_sync_misc (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   ({link_select_jumper_c_i, link_select_jumper_b_i, link_select_jumper_a_i,
                     volt_12_sw_i, iris_motor_sw_i, focus_motor_sw_i, zoom_motor_sw_i,
                     setup_button_i, net_connected_i}),
        .sync_o    ({jmp_sync, lens_sync, btn_sync, conn_sync})
    );

    // Wait two edges after release so the synchronisers hold real pin levels
    logic [1:0] load_cnt_r;
    logic       load_now;
    assign load_now = (load_cnt_r == 2'h2);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i)
            load_cnt_r <= 2'h0;
        else if (load_cnt_r != 2'h3)
            load_cnt_r <= load_cnt_r + 2'h1;
    end

    // Edge detectors look at the second sync stage only
    logic btn_prev_r;
    logic conn_prev_r;
    logic btn_rise;
    logic conn_rise;
    assign btn_rise  = btn_sync & ~btn_prev_r;
    assign conn_rise = conn_sync & ~conn_prev_r;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            btn_prev_r  <= 1'b1;
            conn_prev_r <= 1'b1;
        end else begin
            btn_prev_r  <= btn_sync;
            conn_prev_r <= conn_sync;
        end
    end

    // Format is frozen after power-up so a transfer never sees it move
    logic [7:0] fmt_r;
    logic       force_def_r;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i)
            fmt_r <= `SLC_FMT_RESET;
        else if (load_now)
            fmt_r <= fmt_sync;  // see [R14]
    end

    logic [2:0] par_code;
    logic       par_valid;
    logic       use_def;
    assign par_code  = fmt_r[`SLC_FMT_PAR_MSB:`SLC_FMT_PAR_LSB];  // see [R2]
    assign par_valid = (par_code == `SLC_PAR_EVEN) || (par_code == `SLC_PAR_ODD)
                    || (par_code == `SLC_PAR_NONE);
    assign use_def   = ~par_valid | force_def_r;  // see [R15]

    // Fixed format wins when selected or when the switches are unusable
    assign stop_two_o    = use_def ? 1'b0 : ~fmt_r[`SLC_FMT_STOP_BIT];      // see [R1] [R4]
    assign data_eight_o  = use_def ? 1'b1 : fmt_r[`SLC_FMT_DATA_BIT];       // see [R1] [R4]
    assign parity_en_o   = ~use_def & (par_code != `SLC_PAR_NONE);          // see [R2] [R4]
    assign parity_odd_o  = ~use_def & (par_code == `SLC_PAR_ODD);           // see [R2]
    assign baud_code_o   = use_def ? `SLC_BAUD_9600
                                   : fmt_r[`SLC_FMT_BAUD_MSB:`SLC_FMT_BAUD_LSB];  // see [R3] [R4]
    assign fmt_default_o = use_def;

    // Node number: weighted positions are just the bank read as binary
    logic [7:0] node_r;
    logic       node_cap;
    assign node_cap = load_now | conn_rise;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i)
            node_r <= `SLC_NODE_RESET;  // see [R7]
        else if (node_cap)
            node_r <= stn_sync;  // see [R5] [R8]
    end

    assign node_number_o = node_r;
    assign node_valid_o  = (node_r >= `SLC_NODE_MIN);  // see [R6] [R15]

    // Link and lens selection
    logic [2:0] jmp_r;
    logic [3:0] lens_r;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            jmp_r  <= 3'h0;
            lens_r <= 4'h0;
        end else begin
            if (load_now)
                jmp_r <= jmp_sync;
            lens_r <= lens_sync;  // see [R13]
        end
    end

    // Serial only with all three jumpers moved; anything partial stays on the network
    assign link_serial_o = &jmp_r;  // see [R12]
    assign zoom_motor_o  = lens_r[0];
    assign focus_motor_o = lens_r[1];
    assign iris_motor_o  = lens_r[2];
    assign volt_12_o     = lens_r[3];

    // APB decode
    logic apb_setup;
    logic apb_write;
    logic sel_fmt;
    logic sel_node;
    logic sel_lens;
    logic sel_ctrl;
    logic sel_test;
    logic sel_hit;
    assign apb_setup = psel_i & ~penable_i;
    assign apb_write = psel_i & penable_i & pwrite_i;
    assign sel_fmt   = (paddr_i == `SLC_ADDR_FMT);
    assign sel_node  = (paddr_i == `SLC_ADDR_NODE);
    assign sel_lens  = (paddr_i == `SLC_ADDR_LENS);
    assign sel_ctrl  = (paddr_i == `SLC_ADDR_CTRL);
    assign sel_test  = (paddr_i == `SLC_ADDR_TEST);
    assign sel_hit   = sel_fmt | sel_node | sel_lens | sel_ctrl | sel_test;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~sel_hit;

    logic sw_start;
    assign sw_start = apb_write & sel_ctrl & pwdata_i[`SLC_CTRL_START_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (reset_i)
            force_def_r <= 1'b0;
        else if (apb_write & sel_ctrl)
            force_def_r <= pwdata_i[`SLC_CTRL_FORCE_BIT];
    end

    // Self-test sequencer
    slc_pkg::slc_state_e st_r;
    slc_pkg::slc_state_e st_nxt;
    logic [31:0]         step_cnt_r;
    logic                step_done;
    logic                start_req;
    assign step_done = (step_cnt_r == STEP_CYCLES - 32'h1);
    assign start_req = btn_rise | sw_start;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            slc_pkg::SLC_ST_IDLE: begin
                if (start_req)
                    st_nxt = slc_pkg::SLC_ST_PAN_POS;  // see [R10]
            end
            slc_pkg::SLC_ST_PAN_POS: begin
                if (step_done)
                    st_nxt = slc_pkg::SLC_ST_PAN_NEG;  // see [R11]
            end
            slc_pkg::SLC_ST_PAN_NEG: begin
                if (step_done)
                    st_nxt = slc_pkg::SLC_ST_TILT_POS;
            end
            slc_pkg::SLC_ST_TILT_POS: begin
                if (step_done)
                    st_nxt = slc_pkg::SLC_ST_TILT_NEG;
            end
            slc_pkg::SLC_ST_TILT_NEG: begin
                if (step_done)
                    st_nxt = slc_pkg::SLC_ST_CENTER;
            end
            slc_pkg::SLC_ST_CENTER: begin
                if (step_done)
                    st_nxt = slc_pkg::SLC_ST_IDLE;  // see [R11]
            end
            default: st_nxt = slc_pkg::SLC_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_r       <= slc_pkg::SLC_ST_IDLE;
            step_cnt_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            if (st_r == slc_pkg::SLC_ST_IDLE || step_done)
                step_cnt_r <= 32'h0;
            else
                step_cnt_r <= step_cnt_r + 32'h1;
        end
    end

    slc_pkg::slc_deg_t pan_nxt;
    slc_pkg::slc_deg_t tilt_nxt;
    assign pan_nxt  = (st_nxt == slc_pkg::SLC_ST_PAN_POS)  ? `SLC_TEST_DEG_POS :
                      (st_nxt == slc_pkg::SLC_ST_PAN_NEG)  ? `SLC_TEST_DEG_NEG :
                                                             `SLC_TEST_DEG_ZERO;
    assign tilt_nxt = (st_nxt == slc_pkg::SLC_ST_TILT_POS) ? `SLC_TEST_DEG_POS :
                      (st_nxt == slc_pkg::SLC_ST_TILT_NEG) ? `SLC_TEST_DEG_NEG :
                                                             `SLC_TEST_DEG_ZERO;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            test_pan_deg_o  <= `SLC_TEST_DEG_ZERO;
            test_tilt_deg_o <= `SLC_TEST_DEG_ZERO;
            test_busy_o     <= 1'b0;
        end else begin
            test_pan_deg_o  <= pan_nxt;   // see [R10]
            test_tilt_deg_o <= tilt_nxt;  // see [R10]
            test_busy_o     <= (st_nxt != slc_pkg::SLC_ST_IDLE);
        end
    end

    // Read data latched in setup so the access phase returns a stable word
    logic [31:0] rd_mux;
    assign rd_mux = sel_fmt  ? {22'h0, use_def, par_valid, fmt_r} :
                    sel_node ? {22'h0, link_serial_o, node_valid_o, node_r} :
                    sel_lens ? {28'h0, lens_r} :
                    sel_ctrl ? {30'h0, force_def_r, 1'b0} :
                    sel_test ? {28'h0, test_busy_o, st_r} :
                               32'h0;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i)
            prdata_o <= 32'h0;
        else if (apb_setup)
            prdata_o <= rd_mux;
    end

    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    property p_stop_data;
        load_now && !force_def_r ##1 par_valid |->
            (stop_two_o == !fmt_r[0]) && (data_eight_o == fmt_r[1]);
    endproperty
    a_stop_data: assert property (p_stop_data)  // see [R1]
        else $error("stop or data bits do not follow the format bank");

    property p_parity;
        !use_def |-> parity_en_o == (par_code != 3'h7) && parity_odd_o == (par_code == 3'h6);
    endproperty
    a_parity: assert property (p_parity)  // see [R2]
        else $error("parity decode wrong");

    property p_baud_latch;
        load_now && !force_def_r |=> use_def || (baud_code_o == $past(fmt_sync[7:5]));
    endproperty
    a_baud_latch: assert property (p_baud_latch)  // see [R3]
        else $error("baud code not taken from positions six to eight");

    property p_default_fmt;
        fmt_default_o |-> baud_code_o == 3'h5 && !parity_en_o && data_eight_o && !stop_two_o;
    endproperty
    a_default_fmt: assert property (p_default_fmt)  // see [R4]
        else $error("default format is not 9600 8N1");

    property p_node_sum;
        node_cap |=> node_number_o == $past(stn_sync);
    endproperty
    a_node_sum: assert property (p_node_sum)  // see [R5]
        else $error("node number not captured from station bank");

    property p_node_range;
        node_valid_o == (node_number_o != 8'h00);
    endproperty
    a_node_range: assert property (p_node_range)  // see [R6]
        else $error("node validity outside 1 to 255");

    property p_node_reset;
        $fell(reset_i) |-> node_number_o == 8'h5a;
    endproperty
    a_node_reset: assert property (disable iff (1'b0) p_node_reset)  // see [R7]
        else $error("node number not 90 after reset");

    property p_node_hold;
        !node_cap |=> $stable(node_number_o);
    endproperty
    a_node_hold: assert property (p_node_hold)  // see [R8]
        else $error("node number moved without reconnection");

    property p_test_seq;
        st_r == slc_pkg::SLC_ST_IDLE && start_req |=>
            test_pan_deg_o == 8'h0a && test_busy_o ##0 test_tilt_deg_o == 8'h00;
    endproperty
    a_test_seq: assert property (p_test_seq)  // see [R10]
        else $error("self-test did not begin with a 10 degree pan");

    property p_test_center;
        st_r == slc_pkg::SLC_ST_TILT_NEG && step_done |=>
            test_pan_deg_o == 8'h00 && test_tilt_deg_o == 8'h00 && test_busy_o;
    endproperty
    a_test_center: assert property (p_test_center)  // see [R11]
        else $error("self-test did not centre after tilt");

    property p_link;
        link_serial_o |-> $past(jmp_r) == 3'h7 || $past(load_now);
    endproperty
    a_link: assert property (p_link)  // see [R12]
        else $error("serial link without all three jumpers");

    property p_fmt_frozen;
        !load_now |=> $stable(fmt_r);
    endproperty
    a_fmt_frozen: assert property (p_fmt_frozen)  // see [R14]
        else $error("format changed after power-up capture");

    property p_bad_parity;
        !par_valid |-> fmt_default_o;
    endproperty
    a_bad_parity: assert property (p_bad_parity)  // see [R15]
        else $error("unused parity code did not force default");

    c_reconnect: cover property (conn_rise ##1 node_number_o != 8'h5a);
    c_full_test: cover property (st_r == slc_pkg::SLC_ST_CENTER ##1 st_r == slc_pkg::SLC_ST_IDLE);
    c_serial:    cover property (link_serial_o && !fmt_default_o);
    c_bad_addr:  cover property (pslverr_o);

endmodule : slc_switch_config

`default_nettype wire

// >>> rtl/slc_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is a slow level; no bus coherency across bits.
`default_nettype none

module slc_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // First stage feeds only the second
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule : slc_sync

`default_nettype wire

// >>> verification/slc_ctrl_model.sv
// Behavioural model of the serial controller beyond the decoder.
// Assumes it only watches the decoder's link and node settings.
`default_nettype none

module slc_ctrl_model (
    input  wire logic [7:0] node_i,
    input  wire logic       node_valid_i,
    input  wire logic       link_serial_i,
    output logic      [7:0] addr_node_o,
    output logic            online_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Software must address the head by its station bank value
    assign addr_node_o = node_i;
    assign online_o    = link_serial_i | node_valid_i;
endmodule : slc_ctrl_model

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the link switch decoder.
// Assumes the decoder's register header and a short STEP_CYCLES.
`default_nettype none
`include "slc_regs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned S = 4;
    logic        ref_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, setup_button_i = 1'b0, net_connected_i = 1'b1;
    logic [7:0]  paddr_i = 8'h00, serial_format_switch_i = 8'h00;
    logic [7:0]  station_number_switch_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        link_select_jumper_a_i = 1'b0, link_select_jumper_b_i = 1'b0;
    logic        link_select_jumper_c_i = 1'b0, zoom_motor_sw_i = 1'b0;
    logic        focus_motor_sw_i = 1'b0, iris_motor_sw_i = 1'b0, volt_12_sw_i = 1'b0;
    logic [31:0] prdata_o, rd_v;
    logic        pready_o, pslverr_o, err_v, ctl_online;
    logic        stop_two_o, data_eight_o, parity_en_o, parity_odd_o, fmt_default_o;
    logic [2:0]  baud_code_o;
    logic [7:0]  node_number_o, test_pan_deg_o, test_tilt_deg_o, ctl_addr, cur_node, fsw;
    logic        node_valid_o, link_serial_o, test_busy_o;
    logic        zoom_motor_o, focus_motor_o, iris_motor_o, volt_12_o;
    logic [7:0]  fmt_w;
    logic [3:0]  lsw;
    int          num_errors = 0;
    int          cmp_count = 0;

    assign fmt_w = {stop_two_o, data_eight_o, parity_en_o, parity_odd_o, baud_code_o,
                    fmt_default_o};

    always #50 ref_clk_i = ~ref_clk_i;

    slc_switch_config #(.STEP_CYCLES(S)) slc_switch_config_i (
        .ref_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .serial_format_switch_i,
        .station_number_switch_i, .link_select_jumper_a_i, .link_select_jumper_b_i,
        .link_select_jumper_c_i, .zoom_motor_sw_i, .focus_motor_sw_i, .iris_motor_sw_i,
        .volt_12_sw_i, .setup_button_i, .net_connected_i, .stop_two_o, .data_eight_o,
        .parity_en_o, .parity_odd_o, .baud_code_o, .fmt_default_o, .node_number_o,
        .node_valid_o, .link_serial_o, .zoom_motor_o, .focus_motor_o, .iris_motor_o,
        .volt_12_o, .test_busy_o, .test_pan_deg_o, .test_tilt_deg_o
    );

    slc_ctrl_model slc_ctrl_model_i (
        .node_i       (node_number_o),
        .node_valid_i (node_valid_o),
        .link_serial_i(link_serial_o),
        .addr_node_o  (ctl_addr),
        .online_o     (ctl_online)
    );

    task automatic conclude();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Unused parity codes fall back to 9600, none, 8 data, 1 stop
    function automatic logic [7:0] exp_fmt(input logic [7:0] sw, input logic frc);
        if (frc || sw[4:2] < 3'h5) return {2'b01, 2'b00, 3'h5, 1'b1};
        return {~sw[0], sw[1], sw[4:2] != 3'h7, sw[4:2] == 3'h6, sw[7:5], 1'b0};
    endfunction : exp_fmt

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            num_errors++;
            conclude();
        end
        rd_v = prdata_o;
        err_v = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk(32'({test_busy_o, node_number_o}), 32'h5a);
        reset_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask : do_reset

    // Bank changes must stay invisible until the connector is cycled
    task automatic reconnect(input logic [7:0] st);
        station_number_switch_i <= st;
        repeat (6) @(posedge ref_clk_i);
        chk(32'(node_number_o), 32'(cur_node));
        net_connected_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        net_connected_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        cur_node = st;
        chk(32'({node_valid_o, node_number_o}), 32'({st != 8'h00, st}));
        chk(32'(ctl_addr), 32'(st));
    endtask : reconnect

    task automatic walk(input logic poke);
        logic [16:0] w [6] = '{17'h10a00, 17'h1f600, 17'h1000a, 17'h100f6, 17'h10000, 17'h0};
        for (int k = 0; k < 6; k++) begin
            if (k > 0) repeat (S) @(posedge ref_clk_i);
            if (k == 1) setup_button_i <= poke;
            if (k == 3) setup_button_i <= 1'b0;
            #1;
            chk(32'({test_busy_o, test_pan_deg_o, test_tilt_deg_o}), 32'(w[k]));
        end
    endtask : walk

    initial begin
        int n;
        void'($urandom(32'h0b71c6b3));
        for (int i = 0; i < 8; i++) begin
            fsw = {3'(7 - i), 3'(i), 2'($urandom)};
            cur_node = 8'($urandom);
            serial_format_switch_i <= fsw;
            station_number_switch_i <= cur_node;
            {link_select_jumper_c_i, link_select_jumper_b_i, link_select_jumper_a_i} <= 3'(i);
            do_reset();
            chk(32'(fmt_w), 32'(exp_fmt(fsw, 1'b0)));
            chk(32'({link_serial_o, node_number_o}), 32'({i == 7, cur_node}));
            chk(32'(ctl_online), 32'(i == 7 || cur_node != 8'h00));
            apb(1'b0, `SLC_ADDR_FMT, 32'h0);
            chk(rd_v, 32'({fsw[4:2] < 3'h5, fsw[4:2] > 3'h4, fsw}));
            apb(1'b0, `SLC_ADDR_NODE, 32'h0);
            chk(rd_v, 32'({i == 7, cur_node != 8'h00, cur_node}));
        end
        serial_format_switch_i <= ~fsw;
        repeat (6) @(posedge ref_clk_i);
        chk(32'(fmt_w), 32'(exp_fmt(fsw, 1'b0)));
        apb(1'b1, `SLC_ADDR_CTRL, 32'h2);
        apb(1'b0, `SLC_ADDR_CTRL, 32'h0);
        chk(rd_v, 32'h2);
        chk(32'(fmt_w), 32'(exp_fmt(fsw, 1'b1)));
        apb(1'b1, `SLC_ADDR_FMT, 32'hffffffff);
        apb(1'b1, `SLC_ADDR_CTRL, 32'h0);
        apb(1'b0, `SLC_ADDR_FMT, 32'h0);
        chk(rd_v, 32'({2'b01, fsw}));
        chk(32'({err_v, fmt_w}), 32'(exp_fmt(fsw, 1'b0)));
        apb(1'b0, 8'h14, 32'h0);
        chk(rd_v, 32'h0);
        chk(32'(err_v), 32'h1);
        reconnect(8'h00);
        reconnect(8'hff);
        reconnect(8'($urandom));
        for (int j = 0; j < 3; j++) begin
            lsw = 4'($urandom);
            {volt_12_sw_i, iris_motor_sw_i, focus_motor_sw_i, zoom_motor_sw_i} <= lsw;
            repeat (4) @(posedge ref_clk_i);
            chk(32'({volt_12_o, iris_motor_o, focus_motor_o, zoom_motor_o}), 32'(lsw));
            apb(1'b0, `SLC_ADDR_LENS, 32'h0);
            chk(rd_v, 32'(lsw));
        end
        apb(1'b1, `SLC_ADDR_CTRL, 32'h1);
        @(posedge ref_clk_i);
        walk(1'b1);
        repeat (3) @(posedge ref_clk_i);
        chk(32'(test_busy_o), 32'h0);
        apb(1'b0, `SLC_ADDR_TEST, 32'h0);
        chk(rd_v, 32'h0);
        setup_button_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (test_busy_o !== 1'b1 && n < 10);
        if (test_busy_o !== 1'b1) begin
            num_errors++;
            conclude();
        end
        walk(1'b0);
        conclude();
    end
endmodule : testbench

`default_nettype wire
